/* File: hdl/panel_pkg.sv */
// constants, codes and carrier types for the front panel program selector
// assumes a 25 MHz system clock and an AXI4-Lite register master
package panel_pkg;
  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_HZ = 25_000_000;
  localparam int MSG_MS = 500;
  localparam int MSG_CYCLES = CLK_HZ / 1000 * MSG_MS;
  localparam int DEBOUNCE_US = 5000;
  localparam int DEBOUNCE_CYCLES = CLK_HZ / 1_000_000 * DEBOUNCE_US;
  localparam int CNT_W = 24;
  // ****************************************************************
  // keys and programs
  // ****************************************************************
  localparam logic [3:0] KEY_DIGIT_MAX = 4'h9;
  localparam logic [3:0] KEY_MINUS = 4'hA;
  localparam logic [3:0] KEY_PROGRAM = 4'hB;
  localparam logic [3:0] KEY_COMMIT = 4'hC;
  localparam logic [3:0] KEY_RECALL = 4'hD;
  localparam logic [3:0] PROG_CLEAR = 4'h0;
  localparam logic [3:0] PROG_RES = 4'h1;
  localparam logic [3:0] PROG_FILTER = 4'h2;
  localparam logic [3:0] PROG_EXCL_LO = 4'h3;
  localparam logic [3:0] PROG_EXCL_HI = 4'h7;
  localparam logic [3:0] PROG_MAX = 4'h8;
  localparam logic [3:0] LEAD_MAX = 4'h1;
  localparam int DIGITS = 7;
  localparam int NUM_CONST = 6;
  localparam logic [2:0] LAST_POS_LO = 3'h5;
  localparam logic [2:0] LAST_POS_HI = 3'h6;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_CONTROL = 8'h04;
  localparam logic [7:0] REG_CONST_DATA = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_IDLE = 2'b00,
    MODE_PROMPT = 2'b01,
    MODE_EDIT = 2'b10
  } mode_type;
  typedef enum logic [2:0] {
    MSG_NONE = 3'b000,
    MSG_PROMPT = 3'b001,
    MSG_PROGNUM = 3'b010,
    MSG_CLEAR = 3'b011,
    MSG_ERROR = 3'b100,
    MSG_BUSY = 3'b101
  } msg_type;
  typedef struct packed {
    logic neg;
    logic [DIGITS-1:0][3:0] dig;
  } const_type;
  localparam const_type CONST_ONE = '{neg: 1'b0, dig: {4'h1, 24'h000000}};
  typedef struct packed {
    logic [21:0] pad;
    logic remoteLit;
    logic lamp;
    logic filterOn;
    logic resHigh;
    mode_type mode;
    logic [3:0] activeProg;
  } status_type;
  typedef struct packed {
    logic [27:0] pad;
    logic [2:0] constSel;
    logic keyEnable;
  } control_type;
  localparam logic [31:0] CONTROL_RESET = 32'h00000001;
  typedef struct packed {
    msg_type msg;
    logic [3:0] msgNum;
    logic editActive;
    logic [2:0] cursor;
    const_type editValue;
    logic lamp;
    logic remoteLit;
    logic resHigh;
    logic filterOn;
    logic [3:0] activeProg;
  } display_type;
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axi_in_type;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_out_type;
endpackage

/* File: hdl/front_panel_program_selector.sv */
// front panel program selector: key decode, program state, constant editor
// assumes a keypad on pins, bus remote events on clk, AXI4-Lite registers
//
// What this block does
// - nine programs, numbered zero through eight
// - program key then digit starts program
// - program zero cancels 3-7, keeps 1-2
// - resolution and filter toggles run alongside
// - programs 3-7 exclusive, newest replaces old
// - new selection allowed without prior clear
// - invalid program number shows error
// - separate constant storage for programs 3, 4, 6 and 7, reset defaults
// - digit written at cursor, cursor moves right
// - leading digit only zero or one
// - invalid editing keys discarded, cursor stays
// - minus key toggles constant sign
// - past last digit cursor wraps left
// - constant stored only on commit key
// - five or six digits after leading
// - remote enable ends programs 3-7 only
// - prompt until digit, invalid shows error
// - 3-7 lock panel keys, busy message
// - program lamp lit while 3-7 run
// - remote lit ignores program key until restore
// - starting 3-7 holds present range
// - program zero shows number then clear
// - power-up selects lower resolution mode
`timescale 1ns/100ps
module front_panel_program_selector #(
  parameter int MSG_CYCLES = panel_pkg::MSG_CYCLES,
  parameter int DEBOUNCE_CYCLES = panel_pkg::DEBOUNCE_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic keyDownPin,
  input wire logic [3:0] keyCodePin,
  input wire logic remoteEnable,
  input wire logic goToLocal,
  input wire logic deviceClear,
  input wire panel_pkg::axi_in_type axiIn,
  output panel_pkg::axi_out_type axiOut,
  output panel_pkg::display_type display,
  output logic panelKeyPulse,
  output logic [3:0] panelKeyCode,
  output logic holdRangePulse
);
  import panel_pkg::*;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [2:0] syncDown;
    logic [2:0][3:0] syncCode;
    logic keyDownDb;
    logic [CNT_W-1:0] dbCnt;
    logic keyEv;
    logic [3:0] keyCode;
    mode_type mode;
    logic [3:0] activeProg;
    logic resHigh;
    logic filterOn;
    logic lamp;
    logic holdRange;
    logic remoteLit;
    logic gtlSeen;
    msg_type msg;
    logic [3:0] msgNum;
    logic [CNT_W-1:0] msgCnt;
    logic clearPending;
    logic [NUM_CONST-1:0][$bits(const_type)-1:0] konst;
    const_type edit;
    logic [2:0] cursor;
    logic [2:0] entered;
    logic [2:0] slot;
    logic [2:0] slotLast;
    logic panelKey;
    logic [3:0] panelCode;
    control_type control;
    axi_out_type bus;
    logic editActive;
  } st_type;
  st_type q;
  st_type d;
  logic act;
  logic isDigit;
  logic [2:0] lastPos;
  logic [CNT_W-1:0] msgLoad;
  logic [CNT_W-1:0] dbLast;
  assign act = q.keyEv & q.control.keyEnable;
  assign isDigit = q.keyCode <= KEY_DIGIT_MAX;
  assign lastPos = q.resHigh ? LAST_POS_HI : LAST_POS_LO;
  assign msgLoad = CNT_W'(MSG_CYCLES - 1);
  assign dbLast = CNT_W'(DEBOUNCE_CYCLES - 1);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [3:0] base;
    d = q;
    base = 4'h0;
    d.keyEv = 1'b0;
    d.panelKey = 1'b0;
    d.holdRange = 1'b0;

    // key synchronise and debounce
    d.syncDown = {q.syncDown[1:0], keyDownPin};
    d.syncCode = {q.syncCode[1:0], keyCodePin};
    if (q.syncDown[1] == q.syncDown[2] && q.syncDown[2] != q.keyDownDb) begin
      if (q.dbCnt == dbLast) begin
        d.dbCnt = '0;
        d.keyDownDb = q.syncDown[2];
        d.keyEv = q.syncDown[2];
        d.keyCode = q.syncCode[2];
      end else begin
        d.dbCnt = q.dbCnt + 1'b1;
      end
    end else begin
      d.dbCnt = '0;
    end

    // message timer
    if (q.msgCnt != '0) begin
      d.msgCnt = q.msgCnt - 1'b1;
    end else if (q.clearPending) begin
      d.msg = MSG_CLEAR;
      d.msgCnt = msgLoad;
      d.clearPending = 1'b0;
    end else if (q.msg != MSG_PROMPT) begin
      d.msg = MSG_NONE;
    end

    // key interpretation
    if (act) begin
      case (q.mode)
        MODE_IDLE: begin
          if (q.keyCode == KEY_PROGRAM) begin
            if (!q.remoteLit) begin
              d.mode = MODE_PROMPT;
              d.msg = MSG_PROMPT;
              d.msgCnt = '0;
              d.clearPending = 1'b0;
            end
          end else if (q.activeProg != PROG_CLEAR) begin
            if (q.keyCode == KEY_RECALL) begin
              d.mode = MODE_EDIT;
              d.slot = q.slot - (q.slot - q.slotLast) - (q.slotLast - q.slot);
            end else begin
              d.msg = MSG_BUSY;
              d.msgCnt = msgLoad;
            end
          end else if (isDigit) begin
            d.panelKey = 1'b1;
            d.panelCode = q.keyCode;
          end
        end
        MODE_PROMPT: begin
          d.mode = MODE_IDLE;
          d.msgCnt = msgLoad;
          if (!isDigit || q.keyCode > PROG_MAX) begin
            d.msg = MSG_ERROR;
          end else begin
            d.msg = MSG_PROGNUM;
            d.msgNum = q.keyCode;
            if (q.keyCode == PROG_CLEAR) begin
              d.activeProg = PROG_CLEAR;
              d.lamp = 1'b0;
              d.clearPending = 1'b1;
            end else if (q.keyCode == PROG_RES) begin
              d.resHigh = !q.resHigh;
            end else if (q.keyCode == PROG_FILTER) begin
              d.filterOn = !q.filterOn;
            end else if (q.keyCode <= PROG_EXCL_HI) begin
              d.activeProg = q.keyCode;
              d.lamp = 1'b1;
              d.holdRange = 1'b1;
              case (q.keyCode)
                4'h3: {base, d.slotLast} = {4'h0, 3'h1};
                4'h4: {base, d.slotLast} = {4'h2, 3'h2};
                4'h6: {base, d.slotLast} = {4'h3, 3'h4};
                4'h7: {base, d.slotLast} = {4'h5, 3'h5};
                default: {base, d.slotLast} = {4'hF, 3'h0};
              endcase
              if (base != 4'hF) begin
                d.mode = MODE_EDIT;
                d.slot = base[2:0];
              end
            end
          end
        end
        MODE_EDIT: begin
          if (q.keyCode == KEY_PROGRAM) begin
            if (!q.remoteLit) begin
              d.mode = MODE_PROMPT;
              d.msg = MSG_PROMPT;
              d.msgCnt = '0;
            end
          end else if (q.keyCode == KEY_MINUS) begin
            d.edit.neg = !q.edit.neg;
          end else if (q.keyCode == KEY_COMMIT) begin
            for (int i = 0; i < DIGITS; i++) begin
              if (q.entered != '0 && 3'(i) >= q.entered) begin
                d.edit.dig[DIGITS-1-i] = 4'h0;
              end
            end
            d.konst[q.slot] = d.edit;
            if (q.slot != q.slotLast) begin
              d.slot = q.slot + 1'b1;
            end else begin
              d.mode = MODE_IDLE;
            end
          end else if (isDigit && !(q.cursor == '0 && q.keyCode > LEAD_MAX)) begin
            d.edit.dig[3'(DIGITS-1) - q.cursor] = q.keyCode;
            if (q.cursor == lastPos) begin
              d.cursor = '0;
              d.entered = 3'(DIGITS);
            end else begin
              d.cursor = q.cursor + 1'b1;
              if (q.entered <= q.cursor) begin
                d.entered = q.cursor + 1'b1;
              end
            end
          end
        end
        default: begin
          d.mode = MODE_IDLE;
        end
      endcase
    end

    // load the editor whenever a new constant slot opens
    if (d.mode == MODE_EDIT && (q.mode != MODE_EDIT || d.slot != q.slot)) begin
      d.edit = d.konst[d.slot];
      d.cursor = '0;
      d.entered = '0;
    end

    // remote events from the instrument bus
    if (remoteEnable) begin
      d.remoteLit = 1'b1;
      d.gtlSeen = 1'b0;
      if (d.activeProg >= PROG_EXCL_LO && d.activeProg <= PROG_EXCL_HI) begin
        d.activeProg = PROG_CLEAR;
        d.lamp = 1'b0;
      end
      d.mode = MODE_IDLE;
    end else if (goToLocal) begin
      d.gtlSeen = 1'b1;
    end else if (deviceClear && q.gtlSeen) begin
      d.remoteLit = 1'b0;
      d.gtlSeen = 1'b0;
    end

    d.editActive = d.mode == MODE_EDIT;
    // register bus
    if (q.bus.awready) begin
      d.bus.awready = 1'b0;
      d.bus.wready = 1'b0;
      d.bus.bvalid = 1'b1;
      d.bus.bresp = RESP_OKAY;
      case (axiIn.awaddr)
        REG_CONTROL: begin
          if (axiIn.wstrb[0]) begin
            d.control = control_type'({24'h000000, axiIn.wdata[7:0]} & CONTROL_RESET | 
              {28'h0000000, axiIn.wdata[3:0]});
          end
        end
        REG_STATUS, REG_CONST_DATA: begin
          d.bus.bresp = RESP_OKAY;
        end
        default: begin
          d.bus.bresp = RESP_SLVERR;
        end
      endcase
    end else if (!q.bus.bvalid && axiIn.awvalid && axiIn.wvalid) begin
      d.bus.awready = 1'b1;
      d.bus.wready = 1'b1;
    end
    if (q.bus.bvalid && axiIn.bready) begin
      d.bus.bvalid = 1'b0;
    end
    if (q.bus.arready) begin
      d.bus.arready = 1'b0;
      d.bus.rvalid = 1'b1;
      d.bus.rresp = RESP_OKAY;
      case (axiIn.araddr)
        REG_STATUS: begin
          d.bus.rdata = status_type'({22'h000000, q.remoteLit, q.lamp, q.filterOn,
            q.resHigh, q.mode, q.activeProg});
        end
        REG_CONTROL: begin
          d.bus.rdata = q.control;
        end
        REG_CONST_DATA: begin
          d.bus.rdata = '0;
          if (q.control.constSel < 3'(NUM_CONST)) begin
            d.bus.rdata = 32'(q.konst[q.control.constSel]);
          end
        end
        default: begin
          d.bus.rdata = '0;
          d.bus.rresp = RESP_SLVERR;
        end
      endcase
    end else if (!q.bus.rvalid && axiIn.arvalid) begin
      d.bus.arready = 1'b1;
    end
    if (q.bus.rvalid && axiIn.rready) begin
      d.bus.rvalid = 1'b0;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.resHigh <= 1'b0;
      q.control <= control_type'(CONTROL_RESET);
      q.konst[0] <= CONST_ONE;
    end else begin
      q <= d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign axiOut = q.bus;
  assign panelKeyPulse = q.panelKey;
  assign panelKeyCode = q.panelCode;
  assign holdRangePulse = q.holdRange;
  assign display = '{msg: q.msg, msgNum: q.msgNum, editActive: q.editActive,
    cursor: q.cursor, editValue: q.edit, lamp: q.lamp, remoteLit: q.remoteLit,
    resHigh: q.resHigh, filterOn: q.filterOn, activeProg: q.activeProg};

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  property p_remote_lock;
    q.remoteLit && act && q.mode == MODE_IDLE && q.keyCode == KEY_PROGRAM
      |=> q.mode == MODE_IDLE;
  endproperty
  a_remote_lock: assert property (p_remote_lock) else $error("program key taken in remote");
  property p_remote_end;
    remoteEnable |=> !q.lamp && q.mode == MODE_IDLE && q.remoteLit;
  endproperty
  a_remote_end: assert property (p_remote_end) else $error("remote enable left program");
  property p_lead_digit;
    act && !remoteEnable && q.mode == MODE_EDIT && q.cursor == '0 && isDigit
      && q.keyCode > LEAD_MAX |=> q.cursor == '0 && $stable(q.edit);
  endproperty
  a_lead_digit: assert property (p_lead_digit) else $error("bad leading digit taken");
  property p_sign;
    act && !remoteEnable && q.mode == MODE_EDIT && q.keyCode == KEY_MINUS
      |=> q.edit.neg != $past(q.edit.neg);
  endproperty
  a_sign: assert property (p_sign) else $error("minus did not toggle sign");
  property p_wrap;
    act && !remoteEnable && q.mode == MODE_EDIT && isDigit && q.cursor == lastPos
      |=> q.cursor == '0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("cursor did not wrap");
  property p_bad_number;
    act && q.mode == MODE_PROMPT && q.keyCode > PROG_MAX |=> q.msg == MSG_ERROR;
  endproperty
  a_bad_number: assert property (p_bad_number) else $error("no error for bad number");
  property p_lamp;
    q.lamp == (q.activeProg >= PROG_EXCL_LO && q.activeProg <= PROG_EXCL_HI);
  endproperty
  a_lamp: assert property (p_lamp) else $error("lamp disagrees with program");
  property p_hold_range;
    act && !remoteEnable && q.mode == MODE_PROMPT && q.keyCode >= PROG_EXCL_LO
      && q.keyCode <= PROG_EXCL_HI |=> holdRangePulse ##1 !holdRangePulse;
  endproperty
  a_hold_range: assert property (p_hold_range) else $error("range not held");
  property p_clear_keeps;
    act && !remoteEnable && q.mode == MODE_PROMPT && q.keyCode == PROG_CLEAR
      |=> $stable(q.resHigh) && $stable(q.filterOn) && !q.lamp && q.clearPending;
  endproperty
  a_clear_keeps: assert property (p_clear_keeps) else $error("clear disturbed toggles");
  property p_key_pulse;
    q.keyEv |=> !q.keyEv;
  endproperty
  a_key_pulse: assert property (p_key_pulse) else $error("key event longer than a cycle");
  c_commit: cover property (act && q.mode == MODE_EDIT && q.keyCode == KEY_COMMIT);
  c_wrap: cover property (act && q.mode == MODE_EDIT && isDigit && q.cursor == lastPos);
  c_clear_msg: cover property (q.msg == MSG_PROGNUM ##1 q.msg == MSG_CLEAR);
  c_busy: cover property (q.msg == MSG_BUSY);
endmodule

/* File: test/keypad_model.sv */
// operator keypad model: one debounced press per call, release first
// assumes the selector samples the pins on rising edges of clk
`timescale 1ns/100ps
module keypad_model #(
  parameter int HOLD = 12
) (
  input wire logic clk,
  output logic keyDownPin,
  output logic [3:0] keyCodePin
);
  initial begin
    keyDownPin = 1'b0;
    keyCodePin = 4'h0;
  end
  // code lines float while no key is down, so they keep toggling
  task automatic press(input logic [3:0] code);
    repeat (HOLD) begin
      @(posedge clk);
      keyDownPin <= 1'b0;
      keyCodePin <= ~keyCodePin;
    end
    @(posedge clk);
    keyDownPin <= 1'b1;
    keyCodePin <= code;
    repeat (HOLD - 1) @(posedge clk);
  endtask
endmodule

/* File: test/front_panel_program_selector_bench.sv */
// self-checking bench for the front panel program selector
// assumes keypad_model on the key pins; register traffic via AXI4-Lite tasks
`timescale 1ns/100ps
module front_panel_program_selector_bench;
  import panel_pkg::*;
  localparam int MSG = 20;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic keyDownPin;
  logic [3:0] keyCodePin;
  logic remoteEnable = 1'b0;
  logic goToLocal = 1'b0;
  logic deviceClear = 1'b0;
  axi_in_type axiIn = '0;
  axi_out_type axiOut;
  display_type display;
  logic panelKeyPulse;
  logic [3:0] panelKeyCode;
  logic holdRangePulse;
  int fails = 0;
  int tests_run = 0;
  int holds = 0;
  int fwds = 0;
  always #20 clk = ~clk;
  front_panel_program_selector #(.MSG_CYCLES(MSG), .DEBOUNCE_CYCLES(3)) dut (
    .clk(clk), .reset_n(reset_n), .keyDownPin(keyDownPin), .keyCodePin(keyCodePin),
    .remoteEnable(remoteEnable), .goToLocal(goToLocal), .deviceClear(deviceClear),
    .axiIn(axiIn), .axiOut(axiOut), .display(display), .panelKeyPulse(panelKeyPulse),
    .panelKeyCode(panelKeyCode), .holdRangePulse(holdRangePulse)
  );
  keypad_model kp (.clk(clk), .keyDownPin(keyDownPin), .keyCodePin(keyCodePin));
  always @(posedge clk) begin
    if (holdRangePulse === 1'b1) holds <= holds + 1;
    if (panelKeyPulse === 1'b1 && panelKeyCode === 4'h2) fwds <= fwds + 1;
  end
  // ****************************************************************
  // bus and compare tasks
  // ****************************************************************
  task automatic axiWrite(input logic [7:0] addr, input logic [31:0] data,
                          input logic [3:0] strb, input logic [1:0] expResp);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    @(posedge clk);
    axiIn.awvalid <= 1'b1;
    axiIn.awaddr <= addr;
    axiIn.wvalid <= 1'b1;
    axiIn.wdata <= data;
    axiIn.wstrb <= strb;
    axiIn.bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge clk);
      if (axiOut.awready === 1'b1) begin
        awDone = 1'b1;
        axiIn.awvalid <= 1'b0;
      end
      if (axiOut.wready === 1'b1) begin
        wDone = 1'b1;
        axiIn.wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (axiOut.bvalid !== 1'b1);
    checkVal(32'(axiOut.bresp), 32'(expResp));
    axiIn.bready <= 1'b0;
  endtask
  task automatic axiRead(input logic [7:0] addr, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    axiIn.arvalid <= 1'b1;
    axiIn.araddr <= addr;
    axiIn.rready <= 1'b1;
    do @(posedge clk); while (axiOut.arready !== 1'b1);
    axiIn.arvalid <= 1'b0;
    do @(posedge clk); while (axiOut.rvalid !== 1'b1);
    d = axiOut.rdata;
    r = axiOut.rresp;
    axiIn.rready <= 1'b0;
  endtask
  task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t value got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic checkReg(input logic [7:0] addr, input logic [31:0] exp,
                          input logic [1:0] expResp);
    logic [31:0] d;
    logic [1:0] r;
    axiRead(addr, d, r);
    tests_run++;
    if (d !== exp || r !== expResp) begin
      fails++;
      $display("ERROR %0t register %0h read %0h resp %0h", $time, addr, d, r);
    end
  endtask
  task automatic give_verdict();
    if (fails == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic testRegs();
    checkReg(REG_STATUS, 32'h0, RESP_OKAY);
    checkReg(REG_CONTROL, CONTROL_RESET, RESP_OKAY);
    checkReg(REG_CONST_DATA, 32'h01000000, RESP_OKAY);
    checkReg(8'h0C, 32'h0, RESP_SLVERR);
    axiWrite(8'h0C, 32'h0000000E, 4'hF, RESP_SLVERR);
    axiWrite(REG_STATUS, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
    axiWrite(REG_CONTROL, 32'h0000000E, 4'hE, RESP_OKAY);
    checkReg(REG_CONTROL, CONTROL_RESET, RESP_OKAY);
    checkReg(REG_STATUS, 32'h0, RESP_OKAY);
    axiWrite(REG_CONTROL, 32'hFFFFFFF0, 4'hF, RESP_OKAY);
    kp.press(KEY_PROGRAM);
    checkVal(display.msg, MSG_NONE);
    axiWrite(REG_CONTROL, 32'hFFFFFFF1, 4'hF, RESP_OKAY);
    checkReg(REG_CONTROL, CONTROL_RESET, RESP_OKAY);
  endtask
  task automatic testPrompt();
    kp.press(KEY_PROGRAM);
    checkVal(display.msg, MSG_PROMPT);
    kp.press(4'h9);
    checkVal(display.msg, MSG_ERROR);
    kp.press(KEY_PROGRAM);
    kp.press(KEY_MINUS);
    checkVal(display.msg, MSG_ERROR);
    kp.press(KEY_PROGRAM);
    kp.press(PROG_MAX);
    checkVal(display.msg, MSG_PROGNUM);
    checkVal(display.msgNum, PROG_MAX);
  endtask
  task automatic testEdit();
    kp.press(KEY_PROGRAM);
    kp.press(4'h3);
    checkVal(32'(holds), 1);
    checkVal(display.lamp, 1);
    checkVal(display.activeProg, 3);
    kp.press(4'h5);
    checkVal(display.cursor, 0);
    kp.press(KEY_RECALL);
    checkVal(display.cursor, 0);
    kp.press(4'h1);
    kp.press(4'h4);
    checkVal(display.cursor, 2);
    checkVal(display.editValue.dig[5], 4);
    repeat (3) kp.press(KEY_MINUS);
    checkVal(display.editValue.neg, 1);
    checkReg(REG_CONST_DATA, 32'h01000000, RESP_OKAY);
    kp.press(KEY_COMMIT);
    checkReg(REG_CONST_DATA, 32'h11400000, RESP_OKAY);
    kp.press(KEY_COMMIT);
    checkVal(display.editActive, 0);
    axiWrite(REG_CONTROL, 32'h3, 4'h1, RESP_OKAY);
    checkReg(REG_CONST_DATA, 32'h0, RESP_OKAY);
  endtask
  task automatic testWrap();
    kp.press(KEY_PROGRAM);
    kp.press(4'h4);
    checkVal(display.activeProg, 4);
    repeat (6) kp.press(4'h1);
    checkVal(display.cursor, 0);
    kp.press(KEY_PROGRAM);
    kp.press(4'h1);
    checkVal(display.resHigh, 1);
    checkVal(display.activeProg, 4);
    kp.press(KEY_RECALL);
    checkVal(display.editValue.dig[6], 0);
    repeat (6) kp.press(4'h1);
    checkVal(display.cursor, 6);
    kp.press(KEY_COMMIT);
    kp.press(4'h2);
    checkVal(display.msg, MSG_BUSY);
    checkVal(32'(fwds), 0);
    checkReg(REG_STATUS, 32'h00000144, RESP_OKAY);
  endtask
  task automatic testRemote();
    @(posedge clk) remoteEnable <= 1'b1;
    @(posedge clk) remoteEnable <= 1'b0;
    @(posedge clk);
    checkVal(display.remoteLit, 1);
    checkVal(display.lamp, 0);
    checkVal(display.activeProg, 0);
    checkVal(display.resHigh, 1);
    kp.press(KEY_PROGRAM);
    checkVal(32'(display.msg == MSG_PROMPT), 0);
    @(posedge clk) goToLocal <= 1'b1;
    @(posedge clk) goToLocal <= 1'b0;
    repeat (3) @(posedge clk);
    deviceClear <= 1'b1;
    @(posedge clk) deviceClear <= 1'b0;
    repeat (2) @(posedge clk);
    checkVal(display.remoteLit, 0);
  endtask
  task automatic testClear();
    kp.press(KEY_PROGRAM);
    kp.press(4'h2);
    checkVal(display.filterOn, 1);
    kp.press(KEY_PROGRAM);
    kp.press(4'h5);
    checkVal(display.activeProg, 5);
    kp.press(KEY_PROGRAM);
    kp.press(PROG_CLEAR);
    checkVal(display.msg, MSG_PROGNUM);
    checkVal(display.activeProg, 0);
    checkVal(display.filterOn, 1);
    repeat (MSG) @(posedge clk);
    checkVal(display.msg, MSG_CLEAR);
    kp.press(4'h2);
    checkVal(32'(fwds), 1);
    checkVal(display.filterOn, 1);
    checkVal(display.lamp, 0);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    testRegs();
    testPrompt();
    testEdit();
    testWrap();
    testRemote();
    testClear();
    give_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    give_verdict();
  end
endmodule
